// [src/usbhc_defs.vh]
`ifndef USBHC_DEFS_VH
`define USBHC_DEFS_VH

// ----------------------------------------------------------------
// clock and bus timing
// ----------------------------------------------------------------
`define USBHC_CLK_MHZ      50
`define USBHC_STB_NS       80
`define USBHC_REC_NS       40
`define USBHC_NS_PER_US    1000

// ----------------------------------------------------------------
// command codes with special handling
// ----------------------------------------------------------------
`define USBHC_C_WR_CTLOUT  8'h00
`define USBHC_C_RD_CTLIN   8'h11
`define USBHC_C_VAL_CTLOUT 8'h60
`define USBHC_C_CLR_CTLIN  8'h71
`define USBHC_C_WR_CTLIN   8'h01
`define USBHC_C_RD_CTLOUT  8'h10
`define USBHC_C_UNST_OUT   8'h80
`define USBHC_C_UNST_IN    8'h81
`define USBHC_EP_CTLOUT    4'h0
`define USBHC_EP_CTLIN     4'h1

// ----------------------------------------------------------------
// code groups (upper nibble)
// ----------------------------------------------------------------
`define USBHC_G_BUFW       4'h0
`define USBHC_G_BUFR       4'h1
`define USBHC_G_WCFG       4'h2
`define USBHC_G_RCFG       4'h3
`define USBHC_G_STALL      4'h4
`define USBHC_G_STAT       4'h5
`define USBHC_G_VALID      4'h6
`define USBHC_G_CLEAR      4'h7

// ----------------------------------------------------------------
// transaction classes
// ----------------------------------------------------------------
`define USBHC_K_ILL        3'h0
`define USBHC_K_NODATA     3'h1
`define USBHC_K_W1         3'h2
`define USBHC_K_R1         3'h3
`define USBHC_K_BUFW       3'h4
`define USBHC_K_BUFR       3'h5
`define USBHC_K_GEN        3'h6

// ----------------------------------------------------------------
// packet limits and fifo
// ----------------------------------------------------------------
`define USBHC_MAX_CTL      16'd64
`define USBHC_MAX_BULK     16'd64
`define USBHC_MAX_ISO      16'd1023
`define USBHC_ONE_BYTE     16'd1
`define USBHC_FIFO_W       16
`define USBHC_FIFO_D       16
`define USBHC_FIFO_AW      4

`endif

// [src/usbhc_fifo.v]
`timescale 1ns/1ps
`include "usbhc_defs.vh"

// ----------------------------------------------------------------
// write-data fifo, flip-flop storage
// ----------------------------------------------------------------
module usbhc_fifo
#(
  parameter W  = `USBHC_FIFO_W,
  parameter D  = `USBHC_FIFO_D,
  parameter AW = `USBHC_FIFO_AW
)
(
  input  wire         clk,        // system clock
  input  wire         rst_n,      // synchronised reset, active low
  input  wire         in_valid,   // source offers a word
  output reg          in_ready,   // room for a word
  input  wire [W-1:0] in_data,    // word in
  output wire         out_valid,  // word available
  input  wire         out_ready,  // sink takes the word
  output wire [W-1:0] out_data    // oldest word
);

  reg [W-1:0]  mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;
  wire [AW:0]  cnt_nxt;

  // handshakes and occupancy
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];
  assign cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // pointers, count and registered ready
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r     <= {AW{1'b0}};
      rp_r     <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt < D[AW:0]);
    end
  end

  // storage write
  always @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

endmodule // usbhc_fifo

// [src/usbhc_ctrl.v]
`timescale 1ns/1ps
`include "usbhc_defs.vh"

module usbhc_ctrl
(
  input  wire        sys_clk,    // 50 MHz clock
  input  wire        nrst,       // async reset, active low
  input  wire        bus16,      // 1: 16-bit bus, 0: 8-bit bus
  input  wire        cmd_valid,  // command request
  output reg         cmd_ready,  // controller idle
  input  wire [7:0]  cmd_code,   // command code
  input  wire        cmd_rd,     // generic codes: 1 read
  input  wire [15:0] cmd_len,    // byte count N
  input  wire        cmd_iso,    // endpoint is isochronous
  output reg         cmd_done,   // pulse, transaction over
  output reg         cmd_err,    // pulse, command refused
  input  wire        wr_valid,   // write word offered
  output wire        wr_ready,   // fifo has room
  input  wire [15:0] wr_data,    // write word
  output reg         rd_valid,   // pulse, read word valid
  output reg  [15:0] rd_data,    // read word
  output reg         rd_last,    // with rd_valid: final word
  output reg  [15:0] rd_len,     // packet length from buffer
  output reg         cs_n,       // chip select, active low
  output reg         rd_n,       // read strobe, active low
  output reg         wr_n,       // write strobe, active low
  output reg         cmd_sel,    // command/data select
  output reg  [15:0] d_out,      // data pins out
  output reg         d_oe,       // data pins driven
  input  wire [15:0] d_in        // data pins in
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam integer STB_I = (`USBHC_STB_NS * `USBHC_CLK_MHZ
                             + `USBHC_NS_PER_US - 1) / `USBHC_NS_PER_US;
  localparam integer REC_I = (`USBHC_REC_NS * `USBHC_CLK_MHZ
                             + `USBHC_NS_PER_US - 1) / `USBHC_NS_PER_US;
  localparam [7:0] STB_CYC = STB_I[7:0];
  localparam [7:0] REC_CYC = REC_I[7:0];

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LOAD = 3'h1;
  localparam [2:0] ST_STB  = 3'h2;
  localparam [2:0] ST_REC  = 3'h3;
  localparam [2:0] ST_FIN  = 3'h4;

  localparam [1:0] PH_CMD  = 2'h0;
  localparam [1:0] PH_LEN  = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // accesses needed for n bytes
  function [15:0] beats_of;
    input [15:0] n;
    input        w16;
    reg   [16:0] sum;
    begin
      sum = {1'b0, n} + 17'd1;
      if (w16)
        beats_of = sum[16:1];
      else
        beats_of = n;
    end
  endfunction

  // transaction class of a code
  function [2:0] cls_of;
    input [7:0] c;
    begin
      if (c == `USBHC_C_WR_CTLOUT || c == `USBHC_C_RD_CTLIN ||
          c == `USBHC_C_VAL_CTLOUT || c == `USBHC_C_CLR_CTLIN)
        cls_of = `USBHC_K_ILL;
      else
        case (c[7:4])
          `USBHC_G_BUFW:  cls_of = `USBHC_K_BUFW;
          `USBHC_G_BUFR:  cls_of = `USBHC_K_BUFR;
          `USBHC_G_WCFG:  cls_of = `USBHC_K_W1;
          `USBHC_G_RCFG:  cls_of = `USBHC_K_R1;
          `USBHC_G_STALL: cls_of = `USBHC_K_NODATA;
          `USBHC_G_STAT:  cls_of = `USBHC_K_R1;
          `USBHC_G_VALID: cls_of = `USBHC_K_NODATA;
          `USBHC_G_CLEAR: cls_of = `USBHC_K_NODATA;
          default:
          begin
            if (c == `USBHC_C_UNST_OUT || c == `USBHC_C_UNST_IN)
              cls_of = `USBHC_K_NODATA;
            else
              cls_of = `USBHC_K_GEN;
          end
        endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  reg        rst_m_r;
  reg        rst_s_r;
  reg [15:0] din_m_r;
  reg [15:0] din_s_r;
  wire       rst_n;

  assign rst_n = rst_s_r;

  // reset release through two flops
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // data pins into the clock domain
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_m_r <= 16'h0000;
      din_s_r <= 16'h0000;
    end
    else
    begin
      din_m_r <= d_in;
      din_s_r <= din_m_r;
    end
  end

  // ----------------------------------------------------------------
  // write data fifo
  // ----------------------------------------------------------------
  reg         pop_r;
  wire        fifo_valid;
  wire [15:0] fifo_data;

  usbhc_fifo #(
    .W  (`USBHC_FIFO_W),
    .D  (`USBHC_FIFO_D),
    .AW (`USBHC_FIFO_AW)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (pop_r),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // request check
  // ----------------------------------------------------------------
  wire [2:0]  req_cls;
  wire [15:0] req_max;
  wire        req_bad;
  wire        is_ctl;

  // buffer size limit by endpoint kind
  assign req_cls = cls_of(cmd_code);
  assign is_ctl  = (cmd_code[3:0] == `USBHC_EP_CTLIN) ||
                   (cmd_code[3:0] == `USBHC_EP_CTLOUT);
  assign req_max = is_ctl ? `USBHC_MAX_CTL :
                   (cmd_iso ? `USBHC_MAX_ISO : `USBHC_MAX_BULK);
  assign req_bad = (req_cls == `USBHC_K_ILL) ||
                   (req_cls == `USBHC_K_BUFW && cmd_len > req_max);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  reg [2:0]  st_r;
  reg [1:0]  ph_r;
  reg [2:0]  cls_r;
  reg [7:0]  code_r;
  reg        w16_r;
  reg        rdir_r;
  reg        lidx_r;
  reg [15:0] n_r;
  reg [15:0] beats_r;
  reg [7:0]  cnt_r;
  wire       last_w;

  assign last_w = (beats_r == 16'd1);

  // bus cycles for command, length and data phases
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= ST_IDLE;
      ph_r      <= PH_CMD;
      cls_r     <= `USBHC_K_ILL;
      code_r    <= 8'h00;
      w16_r     <= 1'b0;
      rdir_r    <= 1'b0;
      lidx_r    <= 1'b0;
      n_r       <= 16'h0000;
      beats_r   <= 16'h0000;
      cnt_r     <= 8'h00;
      pop_r     <= 1'b0;
      cmd_ready <= 1'b0;
      cmd_done  <= 1'b0;
      cmd_err   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 16'h0000;
      rd_last   <= 1'b0;
      rd_len    <= 16'h0000;
      cs_n      <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      cmd_sel   <= 1'b0;
      d_out     <= 16'h0000;
      d_oe      <= 1'b0;
    end
    else
    begin
      pop_r    <= 1'b0;
      cmd_done <= 1'b0;
      cmd_err  <= 1'b0;
      rd_valid <= 1'b0;
      rd_last  <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            if (req_bad)
              cmd_err <= 1'b1;
            else
            begin
              code_r <= cmd_code;
              cls_r  <= req_cls;
              w16_r  <= bus16;
              rdir_r <= (req_cls == `USBHC_K_R1) ||
                        (req_cls == `USBHC_K_BUFR) ||
                        (req_cls == `USBHC_K_GEN && cmd_rd);
              n_r    <= (req_cls == `USBHC_K_W1 || req_cls == `USBHC_K_R1)
                        ? `USBHC_ONE_BYTE : cmd_len;
              ph_r   <= PH_CMD;
              st_r   <= ST_LOAD;
            end
          end
        end
        ST_LOAD:
        begin
          cnt_r <= STB_CYC - 8'd1;
          if (ph_r == PH_CMD)
          begin
            // command byte, upper lane zero
            cmd_sel <= 1'b1;
            d_out   <= {8'h00, code_r};
            d_oe    <= 1'b1;
            cs_n    <= 1'b0;
            wr_n    <= 1'b0;
            st_r    <= ST_STB;
          end
          else if (rdir_r)
          begin
            cmd_sel <= 1'b0;
            d_oe    <= 1'b0;
            cs_n    <= 1'b0;
            rd_n    <= 1'b0;
            st_r    <= ST_STB;
          end
          else if (ph_r == PH_LEN)
          begin
            // length word, or low then high byte
            cmd_sel <= 1'b0;
            d_out   <= w16_r ? n_r :
                       {8'h00, (lidx_r ? n_r[15:8] : n_r[7:0])};
            d_oe    <= 1'b1;
            cs_n    <= 1'b0;
            wr_n    <= 1'b0;
            st_r    <= ST_STB;
          end
          else if (fifo_valid)
          begin
            // data word from fifo, stall while empty
            cmd_sel <= 1'b0;
            d_out   <= w16_r ? fifo_data : {8'h00, fifo_data[7:0]};
            d_oe    <= 1'b1;
            cs_n    <= 1'b0;
            wr_n    <= 1'b0;
            pop_r   <= 1'b1;
            st_r    <= ST_STB;
          end
        end
        ST_STB:
        begin
          if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'd1;
          else
          begin
            cs_n  <= 1'b1;
            rd_n  <= 1'b1;
            wr_n  <= 1'b1;
            cnt_r <= REC_CYC - 8'd1;
            st_r  <= ST_REC;
            if (rdir_r && ph_r == PH_LEN)
            begin
              // capture packet length, low part first
              if (w16_r)
                n_r <= din_s_r;
              else if (!lidx_r)
                n_r <= {8'h00, din_s_r[7:0]};
              else
                n_r <= {din_s_r[7:0], n_r[7:0]};
            end
            if (rdir_r && ph_r == PH_DATA)
            begin
              rd_valid <= 1'b1;
              rd_last  <= last_w;
              if (!w16_r || cls_r == `USBHC_K_R1 ||
                  (last_w && n_r[0]))
                rd_data <= {8'h00, din_s_r[7:0]};
              else
                rd_data <= din_s_r;
            end
          end
        end
        ST_REC:
        begin
          d_oe <= 1'b0;
          if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'd1;
          else if (ph_r == PH_CMD)
          begin
            lidx_r  <= 1'b0;
            beats_r <= beats_of(n_r, w16_r);
            if (cls_r == `USBHC_K_BUFW || cls_r == `USBHC_K_BUFR)
            begin
              ph_r <= PH_LEN;
              st_r <= ST_LOAD;
            end
            else if (cls_r == `USBHC_K_NODATA ||
                     beats_of(n_r, w16_r) == 16'h0000)
              st_r <= ST_FIN;
            else
            begin
              ph_r <= PH_DATA;
              st_r <= ST_LOAD;
            end
          end
          else if (ph_r == PH_LEN)
          begin
            if (!w16_r && !lidx_r)
            begin
              lidx_r <= 1'b1;
              st_r   <= ST_LOAD;
            end
            else
            begin
              rd_len  <= n_r;
              beats_r <= beats_of(n_r, w16_r);
              if (n_r == 16'h0000)
                st_r <= ST_FIN;
              else
              begin
                ph_r <= PH_DATA;
                st_r <= ST_LOAD;
              end
            end
          end
          else
          begin
            beats_r <= beats_r - 16'd1;
            st_r    <= last_w ? ST_FIN : ST_LOAD;
          end
        end
        ST_FIN:
        begin
          cmd_done <= 1'b1;
          cmd_sel  <= 1'b0;
          st_r     <= ST_IDLE;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // usbhc_ctrl

// [testbench/usbhc_ctrl_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the command controller
// ----------------------------------------------------------------
module usbhc_ctrl_chk
(
  input wire        sys_clk,   // clock
  input wire        nrst,      // reset, active low
  input wire        bus16,     // bus width
  input wire        cmd_valid, // request
  input wire        cmd_ready, // idle
  input wire [7:0]  cmd_code,  // code
  input wire [15:0] cmd_len,   // byte count
  input wire        cmd_iso,   // iso endpoint
  input wire        cmd_done,  // done pulse
  input wire        cmd_err,   // refusal pulse
  input wire        rd_valid,  // read word
  input wire [15:0] rd_data,   // read data
  input wire        rd_last,   // final word
  input wire        cs_n,      // select
  input wire        rd_n,      // read strobe
  input wire        wr_n,      // write strobe
  input wire        cmd_sel,   // command phase
  input wire [15:0] d_out,     // pins out
  input wire        d_oe       // pins driven
);
  // request taken, code classes
  wire tk  = cmd_valid && cmd_ready;
  wire ill = cmd_code == 8'h00 || cmd_code == 8'h11 ||
             cmd_code == 8'h60 || cmd_code == 8'h71;
  wire bw  = cmd_code[7:4] == 4'h0 && cmd_code != 8'h00;
  wire nd  = cmd_code[7:4] == 4'h4 || cmd_code[7:1] == 7'h40;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_bad_code: assert property (tk && ill |=> cmd_err && cs_n)
    else $error("illegal code not refused");
  chk_over_len: assert property (
    tk && bw && !cmd_iso && cmd_len > 16'd64 |=> cmd_err)
    else $error("oversize packet not refused");
  chk_iso_len: assert property (
    tk && bw && cmd_iso && cmd_len > 16'd1023 |=> cmd_err)
    else $error("oversize iso packet not refused");
  chk_nodata_walk: assert property (
    tk && nd |-> ##2 (!wr_n && cmd_sel &&
    d_out[7:0] == $past(cmd_code, 2)) ##7 cmd_done)
    else $error("no-data command walk wrong");
  chk_cfg_read: assert property (
    tk && cmd_code[7:4] == 4'h3 |-> ##2 (!wr_n && cmd_sel)
    ##[1:8] (!rd_n && !cmd_sel))
    else $error("config read phases wrong");
  chk_stb_width: assert property (
    $fell(rd_n) || $fell(wr_n) |-> (!rd_n || !wr_n) [*4]
    ##1 (rd_n && wr_n))
    else $error("strobe width wrong");
  chk_sel_hold: assert property (
    $fell(wr_n) |=> ($stable(cmd_sel) && $stable(d_out)) [*3])
    else $error("phase or data moved under strobe");
  chk_no_fight: assert property (!rd_n |-> !d_oe && !cs_n && wr_n)
    else $error("pins driven during read");
  chk_byte_upper: assert property (
    rd_valid && !bus16 |-> rd_data[15:8] == 8'h00)
    else $error("upper byte not cleared");
  chk_last_valid: assert property (rd_last |-> rd_valid)
    else $error("last without valid");
  chk_done_ready: assert property (cmd_done |=> cmd_ready)
    else $error("not idle after done");

  // main scenarios
  cov_unload: cover property (tk && cmd_code[7:4] == 4'h1);
  cov_last: cover property (rd_last);
  cov_refuse: cover property (cmd_err);
endmodule // usbhc_ctrl_chk

bind usbhc_ctrl usbhc_ctrl_chk i_chk (.sys_clk, .nrst, .bus16, .cmd_valid,
  .cmd_ready, .cmd_code, .cmd_len, .cmd_iso, .cmd_done, .cmd_err,
  .rd_valid, .rd_data, .rd_last, .cs_n, .rd_n, .wr_n, .cmd_sel, .d_out,
  .d_oe);

// [testbench/usbhc_dev_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural model of the peripheral behind the bus
// ----------------------------------------------------------------
module usbhc_dev_model
(
  input wire        sys_clk, // clock
  input wire        bus16,   // bus width
  input wire        cs_n,    // select
  input wire        rd_n,    // read strobe
  input wire        wr_n,    // write strobe
  input wire        cmd_sel, // command phase
  input wire [15:0] d_out,   // pins from host
  output reg [15:0] d_in     // pins to host
);
  reg [7:0]  code_r = 8'h00;
  reg [15:0] olen = 16'h0000;
  reg [15:0] last_r = 16'h0000;
  reg [15:0] stall_r = 16'h0000;
  reg        wp_r = 1'b1;
  reg        rp_r = 1'b1;
  reg [16:0] wlog [0:2047];
  reg [7:0]  cfg [0:15];
  integer    idx = 0;
  integer    wn = 0;

  function [7:0] pb(input integer x);
    pb = x * 3 + 1;
  endfunction

  // read mux, inverse of last value when released
  always_comb
  begin
    if (cs_n || rd_n)
      d_in = ~last_r;
    else if (code_r[7:4] == 4'h1 && bus16)
      d_in = idx == 0 ? olen : {pb(2 * idx - 1), pb(2 * idx - 2)};
    else if (code_r[7:4] == 4'h1)
      d_in = {8'h5a, idx == 0 ? olen[7:0] : idx == 1 ? olen[15:8] :
              pb(idx - 2)};
    else if (code_r[7:4] == 4'h3)
      d_in = {8'ha5, cfg[code_r[3:0]]};
    else
      d_in = {8'ha5, 7'h00, stall_r[code_r[3:0]]};
  end

  // capture accesses at strobe edges
  always @(posedge sys_clk)
  begin
    wp_r <= wr_n;
    rp_r <= rd_n;
    if (!rd_n)
      last_r <= d_in;
    if (!rp_r && rd_n)
      idx <= idx + 1;
    if (!cs_n && !wr_n && wp_r)
    begin
      wlog[wn] <= {cmd_sel, d_out};
      wn <= wn + 1;
      if (cmd_sel)
      begin
        code_r <= d_out[7:0];
        idx <= 0;
        if (d_out[7:4] == 4'h4)
          stall_r[d_out[3:0]] <= 1'b1;
        if (d_out[7:1] == 7'h40)
          stall_r[d_out[3:0]] <= 1'b0;
      end
      else
      begin
        idx <= idx + 1;
        if (code_r[7:4] == 4'h2)
          cfg[code_r[3:0]] <= d_out[7:0];
      end
    end
  end
endmodule // usbhc_dev_model

// [testbench/usbhc_ctrl_tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module usbhc_ctrl_tb;
  reg         sys_clk = 1'b0;
  reg         nrst = 1'b0;
  reg         bus16 = 1'b0;
  reg         cmd_valid = 1'b0;
  reg         cmd_rd = 1'b0;
  reg         cmd_iso = 1'b0;
  reg         wr_valid = 1'b0;
  reg  [7:0]  cmd_code = 8'h00;
  reg  [15:0] cmd_len = 16'h0000;
  reg  [15:0] wr_data = 16'h0000;
  wire        cmd_ready, cmd_done, cmd_err, wr_ready, rd_valid, rd_last;
  wire        cs_n, rd_n, wr_n, cmd_sel, d_oe;
  wire [15:0] rd_data, rd_len, d_out, d_in;
  integer     miscompares = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     i, k, b, n, lidx;
  reg         sent = 1'b0;
  reg  [1:0]  rdsel = 2'b00;
  reg         m, got_err;
  reg  [7:0]  c, v;
  reg  [15:0] wq[$];
  reg  [15:0] rq[$];
  reg  [7:0]  eb[$];
  reg  [7:0]  bad [7] = '{8'h00, 8'h11, 8'h60, 8'h71, 8'h01, 8'h05, 8'h0e};
  reg  [15:0] blen [7] = '{16'd2, 16'd2, 16'd2, 16'd2, 16'd65, 16'd65,
                           16'd1024};

  usbhc_ctrl i_dut (.sys_clk, .nrst, .bus16, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_rd, .cmd_len, .cmd_iso, .cmd_done, .cmd_err, .wr_valid,
    .wr_ready, .wr_data, .rd_valid, .rd_data, .rd_last, .rd_len, .cs_n,
    .rd_n, .wr_n, .cmd_sel, .d_out, .d_oe, .d_in);
  usbhc_dev_model i_dev (.sys_clk, .bus16, .cs_n, .rd_n, .wr_n, .cmd_sel,
    .d_out, .d_in);

  // clock
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  function [7:0] pb(input integer x);
    pb = x * 3 + 1;
  endfunction

  // expected read word x of an unload
  function [15:0] rexp(input integer x);
    if (!m)
      rexp = {8'h00, pb(x)};
    else
      rexp = {2 * x + 1 < n ? pb(2 * x + 1) : 8'h00, pb(2 * x)};
  endfunction

  task end_sim;
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input [16:0] seen, input [16:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // issue one command and wait for done or refusal
  task run(input [7:0] cc, input [15:0] nn, input iso, input mm);
    k = 0;
    while (!cmd_ready && k < 50)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
    bus16 = mm;
    cmd_code = cc;
    cmd_len = nn;
    cmd_iso = iso;
    cmd_rd = rdsel[1] ? rdsel[0] : 1'($urandom);
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (!cmd_done && !cmd_err)
      @(negedge sys_clk);
    got_err = cmd_err;
    @(negedge sys_clk);
  endtask

  // load a packet through the fifo, check what reached the device
  task bufw(input [7:0] cc, input integer nn, input iso, input mm);
    n = nn;
    m = mm;
    eb.delete();
    for (k = 0; k < n; k++)
      eb.push_back(8'($urandom));
    for (k = 0; k < n; k = k + 1 + m)
      wq.push_back({m && k + 1 < n ? eb[k + 1] : 8'($urandom), eb[k]});
    repeat (20) @(negedge sys_clk);
    chk("wr_ready", wr_ready, (m ? (n + 1) / 2 : n) < 16);
    b = i_dev.wn;
    run(cc, n, iso, m);
    chk("drain", wq.size(), 0);
    chk("w_acc", i_dev.wn - b, m ? 2 + (n + 1) / 2 : 3 + n);
    chk("w_len", m ? i_dev.wlog[b + 1] : {1'b0, i_dev.wlog[b + 2][7:0],
        i_dev.wlog[b + 1][7:0]}, n);
    for (k = 0; k < n; k++)
      chk("w_byte", m ? i_dev.wlog[b + 2 + k / 2][8 * (k % 2) +: 8] :
          i_dev.wlog[b + 3 + k][7:0], eb[k]);
  endtask

  // unload a packet, check words handed out
  task bufr(input [7:0] cc, input integer nn, input mm);
    n = nn;
    m = mm;
    i_dev.olen = n;
    rq.delete();
    lidx = 0;
    run(cc, 16'($urandom), 1'b0, m);
    chk("rd_len", rd_len, n);
    chk("r_cnt", rq.size(), m ? (n + 1) / 2 : n);
    chk("r_last", lidx, rq.size());
    for (k = 0; k < rq.size(); k++)
      chk("r_word", rq[k], rexp(k));
  endtask

  // read collector and fifo feeder
  always @(negedge sys_clk)
  begin
    if (rd_valid)
      rq.push_back(rd_data);
    if (rd_valid && rd_last)
      lidx = rq.size();
    if (sent)
      void'(wq.pop_front());
    wr_valid = wq.size() > 0;
    if (wr_valid)
      wr_data = wq[0];
    sent = wr_valid && wr_ready;
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hdfe5));
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("ready", cmd_ready, 1);
    for (i = 0; i < 256; i++)
    begin
      c = i;
      if (c[7:4] == 4'h4 || c[7:1] == 7'h40 || (c[7:4] == 4'h6 &&
          c != 8'h60) || (c[7:4] == 4'h7 && c != 8'h71))
      begin
        b = i_dev.wn;
        run(c, 16'($urandom), 1'b0, 1'($urandom));
        chk("nd_acc", i_dev.wn - b, 1);
        chk("nd_code", {i_dev.wlog[b][16], i_dev.wlog[b][7:0]},
            {1'b1, c});
      end
    end
    for (i = 0; i < 16; i++)
    begin
      rq.delete();
      run(8'h50 | i[3:0], 16'd1, 1'b0, i[0]);
      chk("status", rq[0], {15'h0, i > 1});
    end
    for (i = 0; i < 7; i++)
    begin
      b = i_dev.wn;
      run(bad[i], blen[i], i == 6, 1'b1);
      chk("refuse", got_err, 1);
      chk("ref_acc", i_dev.wn - b, 0);
    end
    for (i = 0; i < 32; i++)
    begin
      c = i;
      v = $urandom;
      wq.push_back({8'($urandom), v});
      run(8'h20 | c[3:0], 16'd1, 1'b0, c[4]);
      rq.delete();
      run(8'h30 | c[3:0], 16'd1, 1'b0, c[4]);
      chk("cfg", rq[0], {8'h00, v});
      chk("cfg_n", rq.size(), 1);
    end
    for (i = 0; i < 4; i++)
    begin
      rdsel = {1'b1, i[1]};
      b = i_dev.wn;
      rq.delete();
      for (k = 0; !i[1] && k < 3 - i[0]; k++)
        wq.push_back(16'($urandom));
      run(8'hb2 | i[1], 16'd3, 1'b0, i[0]);
      chk("g_acc", i_dev.wn - b, i[1] ? 1 : 4 - i[0]);
      chk("g_rcnt", rq.size(), i[1] ? 3 - i[0] : 0);
      if (i[1])
        chk("g_word", rq[0], i[0] ? 16'ha501 : 16'h0001);
    end
    rdsel = 2'b00;
    bufw(8'h01, 64, 1'b0, 1'b1);
    bufw(8'h01, 1, 1'b0, 1'b0);
    bufw(8'h0e, 1023, 1'b1, 1'b1);
    for (i = 0; i < 6; i++)
      bufw(8'(2 + $urandom % 14), 1 + $urandom % 64, 1'b0, 1'($urandom));
    bufr(8'h10, 64, 1'b1);
    bufr(8'h10, 1, 1'b0);
    bufr(8'h1f, 1023, 1'b1);
    for (i = 0; i < 6; i++)
      bufr(8'(8'h12 + $urandom % 14), 1 + $urandom % 64, 1'($urandom));
    end_sim;
  end
endmodule // usbhc_ctrl_tb
